// *** rfa_defs.svh ***
/*
 * Shared constants for the register field access library: widths, offsets,
 * field positions and reset values of the demonstration register bank.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef RFA_DEFS_SVH
`define RFA_DEFS_SVH

// ----------------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------------
`define RFA_DW 32
`define RFA_AW 12
`define RFA_ZERO 32'h0000_0000

// ----------------------------------------------------------------------------
// Register offsets relative to the module base
// ----------------------------------------------------------------------------
`define RFA_OFS_CTRL 12'h000
`define RFA_OFS_STAT 12'h004
`define RFA_OFS_SET 12'h008
`define RFA_OFS_CNT 12'h00c
`define RFA_OFS_EVCLR 12'h010
`define RFA_OFS_ID 12'h014

// ----------------------------------------------------------------------------
// Field layouts: implemented bits per register, others are reserved
// ----------------------------------------------------------------------------
`define RFA_CTRL_MASK 32'h0000_ffff
`define RFA_STAT_MASK 32'h0000_00ff
`define RFA_SET_MASK 32'h0000_00ff
`define RFA_CNT_MASK 32'h0000_00ff
`define RFA_ID_MASK 32'h0000_ffff

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RFA_CTRL_RST 32'h0000_0001
`define RFA_STAT_RST 32'h0000_0000
`define RFA_SET_RST 32'h0000_0000
`define RFA_CNT_RST 32'h0000_0000
// Identity value is arbitrary, it names no real part
`define RFA_ID_VAL 32'h0000_5a01
`define RFA_CNT_ONE 8'h01
`define RFA_CNT_MAX 8'hff

`endif

// *** rfa_pkg.sv ***
/*
 * Types for the register field access library.
 * Assumes rfa_defs.svh is on the include path.
 */
`default_nettype none
`include "rfa_defs.svh"

package rfa_pkg;
    // Field access behaviours a bank bit can have
    typedef enum logic [2:0] {
        RFA_RW,
        RFA_RO,
        RFA_RC,
        RFA_W1C,
        RFA_W1S,
        RFA_WO
    } rfa_access_t;

    // One software access as seen by a field cell
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`RFA_DW-1:0] wdata;
    } rfa_acc_t;

    // Bus request from the processor side
    typedef struct packed {
        logic sel;
        logic write;
        logic [`RFA_AW-1:0] addr;
        logic [`RFA_DW-1:0] wdata;
    } rfa_req_t;
endpackage

`default_nettype wire

// *** rfa_field.sv ***
/*
 * One register of parameterised access type. Bits outside MASK are reserved:
 * they hold no state and read as zero.
 * Assumes the bank delivers at most one access per cycle, single clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rfa_defs.svh"

module rfa_field
    import rfa_pkg::*;
#(
    parameter rfa_access_t ACCESS = RFA_RW,
    parameter logic [`RFA_DW-1:0] MASK = `RFA_ZERO,
    parameter logic [`RFA_DW-1:0] RST = `RFA_ZERO
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire rfa_acc_t acc_i,
    input wire logic [`RFA_DW-1:0] hw_set_i,
    output logic [`RFA_DW-1:0] value_o,
    output logic [`RFA_DW-1:0] rdata_o
);
    logic [`RFA_DW-1:0] val_d;
    logic [`RFA_DW-1:0] val_q;

    // ------------------------------------------------------------------------
    // Next value by access type
    // ------------------------------------------------------------------------
    always_comb
    begin
        val_d = val_q;
        unique case (ACCESS)
            RFA_RW:
            begin
                if (acc_i.wr)
                    val_d = acc_i.wdata; // see (RULE3)
            end
            RFA_RO:
            begin
                val_d = hw_set_i; // Software writes ignored, hardware owns it
            end
            RFA_RC:
            begin
                // Hardware loads a whole new value; a load in the same cycle as the read beats the clear
                if (acc_i.rd)
                    val_d = `RFA_ZERO; // see (RULE1)
                if (hw_set_i != `RFA_ZERO)
                    val_d = hw_set_i; // see (RULE13)
            end
            RFA_W1C:
            begin
                // Ones clear only their own bits; set wins over clear
                if (acc_i.wr)
                    val_d = val_q & ~acc_i.wdata; // see (RULE4) see (RULE5)
                val_d = val_d | hw_set_i; // see (RULE13)
            end
            RFA_W1S:
            begin
                if (acc_i.wr)
                    val_d = val_q | acc_i.wdata; // see (RULE6)
            end
            RFA_WO:
            begin
                // Acts as a one-cycle strobe; reads never touch it
                val_d = acc_i.wr ? acc_i.wdata : `RFA_ZERO; // see (RULE11) see (RULE7)
            end
            default:
            begin
                val_d = val_q;
            end
        endcase
        val_d = val_d & MASK; // see (RULE9)
    end

    // Stored state, reset to the documented value
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            val_q <= RST & MASK; // see (RULE12)
        else
            val_q <= val_d;
    end

    assign value_o = val_q;
    // Write-only cells return zero, meaningless by definition
    assign rdata_o = (ACCESS == RFA_WO) ? `RFA_ZERO : val_q; // see (RULE11)
endmodule

`default_nettype wire

// *** rfa_bank.sv ***
/*
 * Demonstration register bank built from field cells of every access type.
 * Assumes a simple one-cycle bus on mclk_i; offsets are module relative.
 */
// Summary of operation
// (RULE1) Read-clear field returns its value, then hardware clears it.
// (RULE2) Software writes the reset value into read-only fields.
// (RULE3) Read/write field stores written value and returns it on reads.
// (RULE4) Write-one-to-clear: zero leaves bit, one clears only that bit.
// (RULE5) Writing back a read status value clears only bits that were set.
// (RULE6) Write-one-to-set: readable, one sets, zero leaves unchanged.
// (RULE7) Write-only clear register reads meaningless and reads affect nothing.
// (RULE8) Software preserves reserved bits across read-modify-write.
// (RULE9) Reserved bits read as zero; software must not rely on it.
// (RULE10) Registers decode at module base plus hexadecimal offset.
// (RULE11) Write-only field accepts writes only; reads return no data.
// (RULE12) Every field takes its reset value after any reset.
// (RULE13) Hardware set beats software clear in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "rfa_defs.svh"

module rfa_bank
    import rfa_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire rfa_req_t req_i,
    input wire logic [`RFA_DW-1:0] stat_evt_i,
    input wire logic [`RFA_DW-1:0] id_val_i,
    input wire logic cnt_evt_i,
    output logic [`RFA_DW-1:0] rdata_o,
    output logic rvalid_o,
    output logic [`RFA_DW-1:0] ctrl_o,
    output logic [`RFA_DW-1:0] set_o,
    output logic [`RFA_DW-1:0] stat_o
);
    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    rfa_acc_t acc_ctrl, acc_stat, acc_set, acc_cnt, acc_evclr, acc_id;
    logic [`RFA_DW-1:0] v_ctrl, v_stat, v_set, v_cnt, v_evclr, v_id;
    logic [`RFA_DW-1:0] r_ctrl, r_stat, r_set, r_cnt, r_evclr, r_id;
    logic [`RFA_DW-1:0] cnt_hw;
    logic [`RFA_DW-1:0] evclr_hw;
    logic [`RFA_DW-1:0] rdata_d, rdata_q;
    logic rvalid_d, rvalid_q;
    logic [`RFA_DW-1:0] ctrl_q, set_q, stat_q;

    // Offset compare selects one register per access
    function automatic rfa_acc_t decode(input rfa_req_t r, input logic [`RFA_AW-1:0] ofs);
        rfa_acc_t a;
        a.wr = r.sel & r.write & (r.addr == ofs); // see (RULE10)
        a.rd = r.sel & ~r.write & (r.addr == ofs); // see (RULE10)
        a.wdata = r.wdata;
        return a;
    endfunction

    assign acc_ctrl = decode(req_i, `RFA_OFS_CTRL);
    assign acc_stat = decode(req_i, `RFA_OFS_STAT);
    assign acc_set = decode(req_i, `RFA_OFS_SET);
    assign acc_cnt = decode(req_i, `RFA_OFS_CNT);
    assign acc_evclr = decode(req_i, `RFA_OFS_EVCLR);
    assign acc_id = decode(req_i, `RFA_OFS_ID);

    // ------------------------------------------------------------------------
    // Field cells
    // ------------------------------------------------------------------------
    rfa_field #(.ACCESS(RFA_RW), .MASK(`RFA_CTRL_MASK), .RST(`RFA_CTRL_RST)) u_ctrl (
        .mclk_i(mclk_i), .rst_i(rst_i), .acc_i(acc_ctrl), .hw_set_i(`RFA_ZERO),
        .value_o(v_ctrl), .rdata_o(r_ctrl));

    // Status bits: events in, cleared by W1C write; the write-only clear register only masks stat_o
    rfa_field #(.ACCESS(RFA_W1C), .MASK(`RFA_STAT_MASK), .RST(`RFA_STAT_RST)) u_stat (
        .mclk_i(mclk_i), .rst_i(rst_i), .acc_i(acc_stat), .hw_set_i(stat_evt_i),
        .value_o(v_stat), .rdata_o(r_stat));

    rfa_field #(.ACCESS(RFA_W1S), .MASK(`RFA_SET_MASK), .RST(`RFA_SET_RST)) u_set (
        .mclk_i(mclk_i), .rst_i(rst_i), .acc_i(acc_set), .hw_set_i(`RFA_ZERO),
        .value_o(v_set), .rdata_o(r_set));

    // Read-clear event counter: the next count is loaded through the hw_set path,
    // so a plain OR never mixes old and new counts; an event in a read cycle restarts at one
    always_comb
    begin
        cnt_hw = `RFA_ZERO;
        if (cnt_evt_i && (acc_cnt.rd || (v_cnt[7:0] != `RFA_CNT_MAX)))
            cnt_hw[7:0] = acc_cnt.rd ? `RFA_CNT_ONE : v_cnt[7:0] + `RFA_CNT_ONE; // see (RULE1)
    end

    rfa_field #(.ACCESS(RFA_RC), .MASK(`RFA_CNT_MASK), .RST(`RFA_CNT_RST)) u_cnt (
        .mclk_i(mclk_i), .rst_i(rst_i), .acc_i(acc_cnt), .hw_set_i(cnt_hw),
        .value_o(v_cnt), .rdata_o(r_cnt));

    rfa_field #(.ACCESS(RFA_WO), .MASK(`RFA_STAT_MASK), .RST(`RFA_ZERO)) u_evclr (
        .mclk_i(mclk_i), .rst_i(rst_i), .acc_i(acc_evclr), .hw_set_i(`RFA_ZERO),
        .value_o(v_evclr), .rdata_o(r_evclr));

    // Identity is read-only; writes are dropped whatever software sends
    assign evclr_hw = id_val_i;
    rfa_field #(.ACCESS(RFA_RO), .MASK(`RFA_ID_MASK), .RST(`RFA_ID_VAL)) u_id (
        .mclk_i(mclk_i), .rst_i(rst_i), .acc_i(acc_id), .hw_set_i(evclr_hw),
        .value_o(v_id), .rdata_o(r_id));

    // ------------------------------------------------------------------------
    // Read mux and registered outputs
    // ------------------------------------------------------------------------
    always_comb
    begin
        rdata_d = `RFA_ZERO; // Unmapped offsets read zero
        unique case (1'b1)
            acc_ctrl.rd: rdata_d = r_ctrl;
            acc_stat.rd: rdata_d = r_stat;
            acc_set.rd: rdata_d = r_set;
            acc_cnt.rd: rdata_d = r_cnt; // Value before the clear, see (RULE1)
            acc_evclr.rd: rdata_d = r_evclr; // see (RULE7)
            acc_id.rd: rdata_d = r_id;
            default: rdata_d = `RFA_ZERO;
        endcase
        rvalid_d = req_i.sel & ~req_i.write;
    end

    // Trade-off: one cycle read latency keeps every output on a flop
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_q <= `RFA_ZERO;
            rvalid_q <= 1'b0;
            ctrl_q <= `RFA_CTRL_RST;
            set_q <= `RFA_SET_RST;
            stat_q <= `RFA_STAT_RST;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            ctrl_q <= v_ctrl;
            set_q <= v_set;
            // Evclr strobe masks status one cycle late; kept simple on purpose
            stat_q <= v_stat & ~v_evclr;
        end
    end

    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;
    assign ctrl_o = ctrl_q;
    assign set_o = set_q;
    assign stat_o = stat_q;
endmodule

`default_nettype wire

// *** rfa_bank_chk.sv ***
/* Port checker for rfa_bank.
 * Assumes one clock domain and the bind below. */
`timescale 1ns/1ps
`default_nettype none
`include "rfa_defs.svh"
module rfa_bank_chk
    import rfa_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire rfa_req_t req_i,
    input wire logic [`RFA_DW-1:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic [`RFA_DW-1:0] ctrl_o,
    input wire logic [`RFA_DW-1:0] set_o
);
    // Request kinds, decoded once
    logic rd_c;
    logic wr_c;
    assign rd_c = req_i.sel && !req_i.write;
    assign wr_c = req_i.sel && req_i.write;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_read_answer: assert property (rd_c |=> rvalid_o)
        else $error("read not answered");
    a_no_stray: assert property (!rd_c |=> !rvalid_o)
        else $error("stray read valid");
    a_resv_zero: assert property (rvalid_o |-> rdata_o[31:16] == 16'h0000)
        else $error("reserved bits not zero");
    a_ctrl_store: assert property ((wr_c && req_i.addr == `RFA_OFS_CTRL) |=> ##1
        ctrl_o == ($past(req_i.wdata, 2) & `RFA_CTRL_MASK))
        else $error("ctrl write lost");
    a_set_ones: assert property ((wr_c && req_i.addr == `RFA_OFS_SET) |=> ##1
        (set_o & $past(req_i.wdata, 2) & `RFA_SET_MASK) == ($past(req_i.wdata, 2) & `RFA_SET_MASK))
        else $error("set bit not set");
    a_set_sticky: assert property ((set_o & $past(set_o)) == $past(set_o))
        else $error("set bit fell");
    a_rd_ctrl: assert property ((rd_c && req_i.addr == `RFA_OFS_CTRL) |=> rdata_o == ctrl_o)
        else $error("ctrl read wrong");
    a_rd_set: assert property ((rd_c && req_i.addr == `RFA_OFS_SET) |=> rdata_o == set_o)
        else $error("set read wrong");
    a_unmapped_zero: assert property ((rd_c && (req_i.addr > `RFA_OFS_ID || req_i.addr[1:0] != 2'b00))
        |=> rdata_o == `RFA_ZERO)
        else $error("unmapped read not zero");
    a_wo_read: assert property ((rd_c && req_i.addr == `RFA_OFS_EVCLR) |=> rdata_o == `RFA_ZERO)
        else $error("write-only read not zero");
endmodule
bind rfa_bank rfa_bank_chk rfa_bank_chk_inst (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .ctrl_o(ctrl_o), .set_o(set_o));
`default_nettype wire

// *** rfa_cpu.sv ***
/* Processor side model: single word reads and writes.
 * Assumes the one-cycle bus of rfa_bank on mclk_i. */
`timescale 1ns/1ps
`default_nettype none
`include "rfa_defs.svh"
module rfa_cpu
    import rfa_pkg::*;
(
    input wire logic mclk_i,
    input wire logic [`RFA_DW-1:0] rdata_i,
    input wire logic rvalid_i,
    output var rfa_req_t req_o
);
    initial req_o = '0;
    // Deselect; scramble the rest so stale values are never trusted
    task automatic idle();
        req_o <= '{1'b0, ~req_o.write, ~req_o.addr, ~req_o.wdata};
    endtask
    task automatic wr(input logic [`RFA_AW-1:0] a, input logic [`RFA_DW-1:0] d);
        @(posedge mclk_i);
        req_o <= '{1'b1, 1'b1, a, d};
        @(posedge mclk_i);
        idle();
    endtask
    // No valid answer gives unknown data, so the caller's compare fails
    task automatic rd(input logic [`RFA_AW-1:0] a, output logic [`RFA_DW-1:0] d);
        @(posedge mclk_i);
        req_o <= '{1'b1, 1'b0, a, ~req_o.wdata};
        @(posedge mclk_i);
        idle();
        #1;
        d = (rvalid_i === 1'b1) ? rdata_i : 'x;
    endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
/* Self-checking bench for rfa_bank.
 * Assumes rfa_cpu as bus master and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "rfa_defs.svh"
module tb_top
    import rfa_pkg::*;
;
    logic mclk_i;
    logic rst_i;
    logic cnt_evt_i;
    logic rvalid_o;
    logic [`RFA_DW-1:0] stat_evt_i, id_val_i, rdata_o, ctrl_o, set_o, stat_o, v;
    rfa_req_t req_i;
    int fails;
    int checks_done;
    rfa_bank rfa_bank_inst (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .stat_evt_i(stat_evt_i),
        .id_val_i(id_val_i), .cnt_evt_i(cnt_evt_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .ctrl_o(ctrl_o), .set_o(set_o), .stat_o(stat_o));
    rfa_cpu rfa_cpu_inst (.mclk_i(mclk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .req_o(req_i));
    always #20 mclk_i = ~mclk_i;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input logic [`RFA_AW-1:0] a);
        rfa_cpu_inst.rd(a, v);
    endtask
    // One-cycle hardware event pulse
    task automatic evt(input logic [31:0] s, input logic c);
        @(posedge mclk_i);
        stat_evt_i <= s;
        cnt_evt_i <= c;
        @(posedge mclk_i);
        stat_evt_i <= '0;
        cnt_evt_i <= 1'b0;
    endtask
    task automatic t_reset();
        repeat (8) @(posedge mclk_i);
        #1;
        chk("ctrl_o", ctrl_o, `RFA_CTRL_RST);
        chk("set_o", set_o, `RFA_SET_RST);
        chk("stat_o", stat_o, `RFA_STAT_RST);
        @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(`RFA_OFS_CTRL);
        chk("ctrl", v, `RFA_CTRL_RST);
        rd(`RFA_OFS_CNT);
        chk("cnt", v, `RFA_CNT_RST);
    endtask
    task automatic t_rw();
        rfa_cpu_inst.wr(`RFA_OFS_CTRL, 32'hffff_a5c3);
        rd(`RFA_OFS_CTRL);
        chk("ctrl", v, 32'h0000_a5c3);
        rfa_cpu_inst.wr(`RFA_OFS_CTRL, v ^ 32'h0000_00ff);
        rd(`RFA_OFS_CTRL);
        chk("ctrl rmw", v, 32'h0000_a53c);
    endtask
    task automatic t_w1c();
        evt(32'h0000_00a5, 1'b0);
        rfa_cpu_inst.wr(`RFA_OFS_STAT, 32'h0000_000f);
        rd(`RFA_OFS_STAT);
        chk("stat", v, 32'h0000_00a0);
        evt(32'h0000_0002, 1'b0);
        rfa_cpu_inst.wr(`RFA_OFS_STAT, v);
        rd(`RFA_OFS_STAT);
        chk("stat back", v, 32'h0000_0002);
        // Clear and set land on one edge; the event must survive
        fork
            rfa_cpu_inst.wr(`RFA_OFS_STAT, 32'h0000_0002);
            evt(32'h0000_0002, 1'b0);
        join
        rd(`RFA_OFS_STAT);
        chk("stat race", v, 32'h0000_0002);
    endtask
    task automatic t_w1s();
        rfa_cpu_inst.wr(`RFA_OFS_SET, 32'h0000_0103);
        rfa_cpu_inst.wr(`RFA_OFS_SET, 32'h0000_0000);
        rd(`RFA_OFS_SET);
        chk("set", v, 32'h0000_0003);
    endtask
    task automatic t_rc();
        repeat (3) evt('0, 1'b1);
        rd(`RFA_OFS_CNT);
        chk("cnt", v, 32'h0000_0003);
        rd(`RFA_OFS_CNT);
        chk("cnt clr", v, `RFA_ZERO);
    endtask
    task automatic t_map();
        rd(`RFA_OFS_EVCLR);
        chk("wo read", v, `RFA_ZERO);
        rd(`RFA_OFS_STAT);
        chk("stat kept", v, 32'h0000_0002);
        rd(12'h0ff);
        chk("unmapped", v, `RFA_ZERO);
        // Clear strobe masks the status view for one cycle, storage untouched
        chk("stat_o pre", stat_o, 32'h0000_0002);
        rfa_cpu_inst.wr(`RFA_OFS_EVCLR, 32'h0000_0002);
        @(posedge mclk_i);
        #1;
        chk("stat_o strobe", stat_o, `RFA_ZERO);
        @(posedge mclk_i);
        #1;
        chk("stat_o after", stat_o, 32'h0000_0002);
        rfa_cpu_inst.wr(`RFA_OFS_ID, `RFA_ID_VAL);
        rd(`RFA_OFS_ID);
        chk("id", v, 32'h0000_1234);
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------
    // Main sequence and watchdog
    // ------------------------------
    initial
    begin
        mclk_i = 1'b0;
        rst_i = 1'b1;
        stat_evt_i = '0;
        cnt_evt_i = 1'b0;
        id_val_i = 32'h0000_1234;
        t_reset();
        t_rw();
        t_w1c();
        t_w1s();
        t_rc();
        t_map();
        tally_and_finish();
    end
    // Run needs about 70 cycles; 2000 leaves ample margin
    initial
    begin
        #80000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
